// ==== mspseq_pkg.sv ====
// Contract
// - segment sixteen ramp time 0..65535 ms, default 500, effective on write
// - segment sixteen idle time 0..32767, default 1, unit set by unit select
// - first and second decel times 0..65535 ms, default 500, immediate
// - trigger mode bit0 clear: trigger rising edge starts run, falling stops
// - trigger mode bit0 set: rising edge starts run, falling edge ignored
// - bit1 clear with input selection: selection change starts new segment
// - bit1 set: selection change ignored, only a fresh trigger starts
// - send mode 0: wait segment done, then idle time, then next command
// - send mode 1: idle timing starts at command issue, then next command
// - segment sixteen speed 0..32767 rpm, default 500, segment running speed
package mspseq_pkg;
  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] MSPSEQ_RAMP_OFS = 8'h00;
  localparam logic [7:0] MSPSEQ_IDLE_OFS = 8'h04;
  localparam logic [7:0] MSPSEQ_DEC1_OFS = 8'h08;
  localparam logic [7:0] MSPSEQ_DEC2_OFS = 8'h0C;
  localparam logic [7:0] MSPSEQ_TRIG_OFS = 8'h10;
  localparam logic [7:0] MSPSEQ_SEND_OFS = 8'h14;
  localparam logic [7:0] MSPSEQ_SRC_OFS = 8'h18;
  localparam logic [7:0] MSPSEQ_SPEED_OFS = 8'h1C;
  localparam logic [7:0] MSPSEQ_UNIT_OFS = 8'h20;
  localparam logic [7:0] MSPSEQ_STAT_OFS = 8'h24;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] MSPSEQ_RAMP_RST = 16'h01F4;
  localparam logic [15:0] MSPSEQ_IDLE_RST = 16'h0001;
  localparam logic [15:0] MSPSEQ_DEC_RST = 16'h01F4;
  localparam logic [15:0] MSPSEQ_TRIG_RST = 16'h0001;
  localparam logic [15:0] MSPSEQ_SEND_RST = 16'h0000;
  localparam logic [15:0] MSPSEQ_SRC_RST = 16'h0000;
  localparam logic [15:0] MSPSEQ_SPEED_RST = 16'h01F4;
  localparam logic [15:0] MSPSEQ_UNIT_RST = 16'h0000;
  // ****************************************
  // field positions, limits, timing
  // ****************************************
  localparam int MSPSEQ_TRIG_HOLD_BIT = 0;
  localparam int MSPSEQ_TRIG_NODI_BIT = 1;
  localparam logic [15:0] MSPSEQ_IDLE_MAX = 16'h7FFF;
  localparam logic [15:0] MSPSEQ_SPEED_MAX = 16'h7FFF;
  localparam logic [15:0] MSPSEQ_SRC_MAX = 16'h0004;
  localparam int MSPSEQ_CLK_HZ = 25000000;
  localparam int MSPSEQ_MS_TIME = 1;
  localparam int MSPSEQ_MS_CYC = MSPSEQ_CLK_HZ / 1000 * MSPSEQ_MS_TIME;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {MSPSEQ_IDLE, MSPSEQ_ISSUE, MSPSEQ_RUN, MSPSEQ_WAIT} mspseq_state_t;
  typedef enum logic [2:0] {
    MSPSEQ_SRC_PARAM, MSPSEQ_SRC_ANA1, MSPSEQ_SRC_ANA2, MSPSEQ_SRC_ANA3, MSPSEQ_SRC_PULSE
  } mspseq_src_t;
endpackage

// ==== mspseq_tick.sv ====
`timescale 1ns/10ps
// ****************************************
// millisecond tick divider
// ****************************************
module mspseq_tick
  import mspseq_pkg::*;
#(
  parameter int DIV = MSPSEQ_MS_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt_r;
  // one-cycle enable every DIV clocks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_r == 32'(DIV - 1)) begin
      cnt_r <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ==== mspseq_top.sv ====
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module mspseq_top
  import mspseq_pkg::*;
#(
  parameter int MS_DIV = MSPSEQ_MS_CYC,
  parameter int SEL_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic segment_trigger_input,
  input wire logic sel_from_di,
  input wire logic [SEL_W-1:0] di_segment_sel,
  input wire logic segment_done,
  output logic cmd_issue,
  output logic [SEL_W-1:0] cmd_segment,
  output logic run_active,
  output logic [15:0] ramp_time,
  output logic [15:0] decel1_time,
  output logic [15:0] decel2_time,
  output logic [15:0] speed_ref,
  output logic [2:0] speed_source
);
  // ****************************************
  // parameter registers
  // ****************************************
  logic [15:0] ramp_r, idle_r, dec1_r, dec2_r, trig_r, send_r, src_r, speed_r, unit_r;
  logic [7:0] awaddr_r, araddr_r;
  logic aw_got_r, w_got_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  mspseq_state_t state_r;
  logic trig_d_r;
  logic [SEL_W-1:0] sel_d_r;
  logic [15:0] idle_cnt_r;
  logic [15:0] unit_cnt_r;
  logic tick;

  // merge byte lanes into a 16 bit register
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
    lane16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction

  // clamp a value to a maximum
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] mx);
    clamp16 = (v > mx) ? mx : v;
  endfunction

  mspseq_tick #(.DIV(MS_DIV)) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick)
  );

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  // write commits once both address and data are captured; the response follows
  wire do_write = aw_got_r && w_got_r && !s_axi_bvalid;
  wire wr_hit = (awaddr_r <= MSPSEQ_UNIT_OFS) && (awaddr_r[1:0] == 2'b00);
  wire wr_ok = wr_hit || (awaddr_r == MSPSEQ_STAT_OFS);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_got_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_got_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register store; values act at once, no shadow copy
  // mode registers merge with their old value so a partial strobe keeps the other byte
  wire [15:0] trig_m = lane16(trig_r, wdata_r, wstrb_r);
  wire [15:0] send_m = lane16(send_r, wdata_r, wstrb_r);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ramp_r <= MSPSEQ_RAMP_RST;
      idle_r <= MSPSEQ_IDLE_RST;
      dec1_r <= MSPSEQ_DEC_RST;
      dec2_r <= MSPSEQ_DEC_RST;
      trig_r <= MSPSEQ_TRIG_RST;
      send_r <= MSPSEQ_SEND_RST;
      src_r <= MSPSEQ_SRC_RST;
      speed_r <= MSPSEQ_SPEED_RST;
      unit_r <= MSPSEQ_UNIT_RST;
    end else if (do_write) begin
      case (awaddr_r)
        MSPSEQ_RAMP_OFS: ramp_r <= lane16(ramp_r, wdata_r, wstrb_r);
        MSPSEQ_IDLE_OFS: begin
          idle_r <= clamp16(lane16(idle_r, wdata_r, wstrb_r), MSPSEQ_IDLE_MAX);
        end
        MSPSEQ_DEC1_OFS: dec1_r <= lane16(dec1_r, wdata_r, wstrb_r);
        MSPSEQ_DEC2_OFS: dec2_r <= lane16(dec2_r, wdata_r, wstrb_r);
        MSPSEQ_TRIG_OFS: trig_r <= {14'h0, trig_m[1:0]};
        MSPSEQ_SEND_OFS: send_r <= {15'h0, send_m[0]};
        MSPSEQ_SRC_OFS: begin
          src_r <= clamp16(lane16(src_r, wdata_r, wstrb_r), MSPSEQ_SRC_MAX);
        end
        MSPSEQ_SPEED_OFS: begin
          speed_r <= clamp16(lane16(speed_r, wdata_r, wstrb_r), MSPSEQ_SPEED_MAX);
        end
        MSPSEQ_UNIT_OFS: unit_r <= lane16(unit_r, wdata_r, wstrb_r);
        default: ;
      endcase
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  logic [15:0] rsel;
  always_comb begin
    case (araddr_r)
      MSPSEQ_RAMP_OFS: rsel = ramp_r;
      MSPSEQ_IDLE_OFS: rsel = idle_r;
      MSPSEQ_DEC1_OFS: rsel = dec1_r;
      MSPSEQ_DEC2_OFS: rsel = dec2_r;
      MSPSEQ_TRIG_OFS: rsel = trig_r;
      MSPSEQ_SEND_OFS: rsel = send_r;
      MSPSEQ_SRC_OFS: rsel = src_r;
      MSPSEQ_SPEED_OFS: rsel = speed_r;
      MSPSEQ_UNIT_OFS: rsel = unit_r;
      MSPSEQ_STAT_OFS: rsel = {12'h0, 2'(state_r), run_active, trig_d_r};
      default: rsel = 16'h0;
    endcase
  end
  wire rd_ok = (araddr_r <= MSPSEQ_STAT_OFS) && (araddr_r[1:0] == 2'b00);
  logic ar_got_r;

  // one cycle to capture the address, one to present data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
      araddr_r <= 8'h00;
      ar_got_r <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_r <= s_axi_araddr;
        ar_got_r <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (ar_got_r && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0, rsel};
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
        ar_got_r <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // trigger and selection detection
  // ****************************************
  wire trig_rise = segment_trigger_input && !trig_d_r;
  wire trig_fall = !segment_trigger_input && trig_d_r;
  // falling edge stops only when hold bit is clear
  wire stop_req = trig_fall && !trig_r[MSPSEQ_TRIG_HOLD_BIT];
  // selection change retriggers only when bit1 clear
  wire sel_chg = sel_from_di && (di_segment_sel != sel_d_r);
  wire start_req = trig_rise || (sel_chg && !trig_r[MSPSEQ_TRIG_NODI_BIT]);
  // unit tick: unit code 0 counts milliseconds, else tens of ms
  wire [15:0] unit_len = (unit_r == 16'h0) ? 16'h0001 : 16'h000A;
  wire unit_tick = tick && (unit_cnt_r + 16'h1 >= unit_len);
  wire idle_over = (idle_cnt_r >= idle_r);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trig_d_r <= 1'b0;
      sel_d_r <= '0;
    end else begin
      trig_d_r <= segment_trigger_input;
      sel_d_r <= di_segment_sel;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // a stop always wins over a start in the same cycle so a run never survives it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= MSPSEQ_IDLE;
      cmd_issue <= 1'b0;
      cmd_segment <= '0;
      run_active <= 1'b0;
      idle_cnt_r <= 16'h0;
      unit_cnt_r <= 16'h0;
    end else begin
      cmd_issue <= 1'b0;
      if (tick) begin
        unit_cnt_r <= unit_tick ? 16'h0 : unit_cnt_r + 16'h1;
      end
      if (unit_tick && !idle_over) begin
        idle_cnt_r <= idle_cnt_r + 16'h1;
      end
      if (stop_req) begin
        state_r <= MSPSEQ_IDLE;
        run_active <= 1'b0;
      end else if (start_req) begin
        state_r <= MSPSEQ_ISSUE;
        run_active <= 1'b1;
        cmd_segment <= di_segment_sel;
      end else begin
        case (state_r)
          MSPSEQ_IDLE: ;
          MSPSEQ_ISSUE: begin
            cmd_issue <= 1'b1;
            idle_cnt_r <= 16'h0;
            unit_cnt_r <= 16'h0;
            state_r <= send_r[0] ? MSPSEQ_WAIT : MSPSEQ_RUN;
          end
          MSPSEQ_RUN: begin
            if (segment_done) begin
              idle_cnt_r <= 16'h0;
              unit_cnt_r <= 16'h0;
              state_r <= MSPSEQ_WAIT;
            end
          end
          MSPSEQ_WAIT: begin
            if (idle_over) begin
              cmd_segment <= cmd_segment + 1'b1;
              state_r <= MSPSEQ_ISSUE;
            end
          end
          default: state_r <= MSPSEQ_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // parameter outputs
  // ****************************************
  // speed source picks stored speed; other sources flagged for the speed path
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ramp_time <= MSPSEQ_RAMP_RST;
      decel1_time <= MSPSEQ_DEC_RST;
      decel2_time <= MSPSEQ_DEC_RST;
      speed_ref <= MSPSEQ_SPEED_RST;
      speed_source <= 3'h0;
    end else begin
      ramp_time <= ramp_r;
      decel1_time <= dec1_r;
      decel2_time <= dec2_r;
      speed_ref <= (src_r == 16'h0) ? speed_r : 16'h0;
      speed_source <= src_r[2:0];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // a start cut short by a stop or a fresh start in the next cycle issues nothing
  a_stop_on_fall: assert property (@(posedge ref_clk) disable iff (rst)
    stop_req |=> !run_active)
    else $error("run not stopped on falling edge");
  a_hold_no_stop: assert property (@(posedge ref_clk) disable iff (rst)
    trig_fall && trig_r[0] && run_active && !start_req |=> run_active)
    else $error("run stopped in hold mode");
  a_start_issue: assert property (@(posedge ref_clk) disable iff (rst)
    start_req && !stop_req ##1 !start_req && !stop_req |=> cmd_issue)
    else $error("no issue after start");
  a_di_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    sel_chg && trig_r[1] && !trig_rise && !stop_req && state_r == MSPSEQ_IDLE
    |=> state_r == MSPSEQ_IDLE)
    else $error("input change started run");
  a_mode0_waits: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == MSPSEQ_RUN && !segment_done && !stop_req && !start_req
    |=> state_r == MSPSEQ_RUN)
    else $error("left run before done");
  a_mode1_wait: assert property (@(posedge ref_clk) disable iff (rst)
    state_r == MSPSEQ_ISSUE && send_r[0] && !stop_req && !start_req
    |=> state_r == MSPSEQ_WAIT)
    else $error("mode one did not wait");
  a_ramp_live: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 ramp_time == $past(ramp_r))
    else $error("ramp not applied");
  a_decel_live: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 decel2_time == $past(dec2_r))
    else $error("decel not applied");
  a_idle_range: assert property (@(posedge ref_clk) disable iff (rst)
    idle_r <= MSPSEQ_IDLE_MAX && speed_r <= MSPSEQ_SPEED_MAX)
    else $error("idle or speed out of range");
  a_src_range: assert property (@(posedge ref_clk) disable iff (rst)
    src_r <= MSPSEQ_SRC_MAX)
    else $error("speed source out of range");
  a_issue_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_issue |=> !cmd_issue)
    else $error("command pulse longer than one cycle");
  c_issue: cover property (@(posedge ref_clk) disable iff (rst) cmd_issue);
  c_stop: cover property (@(posedge ref_clk) disable iff (rst) stop_req && run_active);
  c_next: cover property (@(posedge ref_clk) disable iff (rst)
    state_r == MSPSEQ_WAIT && idle_over);
  c_di_start: cover property (@(posedge ref_clk) disable iff (rst) sel_chg && !trig_r[1]);
endmodule

// ==== mspseq_ctrl_model.sv ====
`timescale 1ns/10ps
// ****************************************
// far-side model: reports segment output complete
// ****************************************
module mspseq_ctrl_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_issue,
  input wire logic [7:0] done_dly,
  output logic segment_done
);
  int cnt;
  // done pulses done_dly cycles after each issued command, one cycle wide
  // a new command restarts the count, as a real stage would abandon the old move
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      segment_done <= 1'b0;
    end else begin
      segment_done <= (cnt == 1);
      if (cmd_issue) begin
        cnt <= done_dly;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ==== mspseq_top_test.sv ====
`timescale 1ns/10ps
module mspseq_top_test;
  import mspseq_pkg::*;
  localparam int MSD = 4;
  logic ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dly;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, e;
  logic [3:0] s_axi_wstrb, di_segment_sel, cmd_segment, s0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic segment_trigger_input, sel_from_di, segment_done, cmd_issue, run_active, ok;
  logic [15:0] ramp_time, decel1_time, decel2_time, speed_ref;
  logic [2:0] speed_source;
  logic [7:0] a;
  int err_total, n_checks, n, i;
  integer seed = 32'h7ee5;
  logic [15:0] rst_tab [8];
  logic [7:0] adr_tab [5];

  mspseq_top #(.MS_DIV(MSD), .SEL_W(4)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .segment_trigger_input(segment_trigger_input), .sel_from_di(sel_from_di),
    .di_segment_sel(di_segment_sel), .segment_done(segment_done), .cmd_issue(cmd_issue),
    .cmd_segment(cmd_segment), .run_active(run_active), .ramp_time(ramp_time),
    .decel1_time(decel1_time), .decel2_time(decel2_time), .speed_ref(speed_ref),
    .speed_source(speed_source));

  mspseq_ctrl_model u_ctrl (.ref_clk(ref_clk), .rst(rst), .cmd_issue(cmd_issue),
    .done_dly(dly), .segment_done(segment_done));

  // ****************************************
  // clock, watchdog, helpers
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // whole sequence needs under a thousand cycles; twenty thousand is ample
  initial begin
    #(40 * 20000);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask

  // stored value after a write: 16-bit registers, some clamped or masked
  function automatic logic [31:0] exp_of(input logic [7:0] ad, input logic [31:0] d);
    logic [15:0] t;
    t = d[15:0];
    if ((ad == MSPSEQ_IDLE_OFS || ad == MSPSEQ_SPEED_OFS) && t > MSPSEQ_IDLE_MAX) t = 16'h7FFF;
    if (ad == MSPSEQ_SRC_OFS && t > MSPSEQ_SRC_MAX) t = MSPSEQ_SRC_MAX;
    if (ad == MSPSEQ_TRIG_OFS) t = t & 16'h0003;
    if (ad == MSPSEQ_SEND_OFS) t = t & 16'h0001;
    return {16'h0000, t};
  endfunction

  // write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic aw, w, b;
    @(posedge ref_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    while (!b) begin
      @(posedge ref_clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (!aw && !w && s_axi_bvalid) begin
        b = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] ad);
    logic ar, got;
    @(posedge ref_clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar = 1'b1;
    got = 1'b0;
    while (!got) begin
      @(posedge ref_clk);
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (!ar && s_axi_rvalid) begin
        got = 1'b1;
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic trg(input logic t);
    @(posedge ref_clk);
    segment_trigger_input <= t;
  endtask

  // counts cycles until the next command pulse, ok low if none within lim
  task automatic wait_issue(input int lim);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmd_issue !== 1'b1 && n < lim);
    ok = (cmd_issue === 1'b1);
  endtask

  task automatic chk_rng(input int lo, input int hi);
    chk({31'h0, ok && n >= lo && n <= hi}, 32'h1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    segment_trigger_input = 1'b0;
    sel_from_di = 1'b0;
    di_segment_sel = 4'h0;
    dly = 8'h14;
    rst = 1'b1;
    rst_tab = '{MSPSEQ_RAMP_RST, MSPSEQ_IDLE_RST, MSPSEQ_DEC_RST, MSPSEQ_DEC_RST,
      MSPSEQ_TRIG_RST, MSPSEQ_SEND_RST, MSPSEQ_SRC_RST, MSPSEQ_SPEED_RST};
    adr_tab = '{MSPSEQ_RAMP_OFS, MSPSEQ_IDLE_OFS, MSPSEQ_DEC1_OFS, MSPSEQ_DEC2_OFS,
      MSPSEQ_SPEED_OFS};
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values of the eight registers below the unit select, and of the live copies
    for (i = 0; i < 8; i++) begin
      rd(8'(i * 4));
      chk(v, {16'h0000, rst_tab[i]});
    end
    chk({ramp_time, decel1_time}, 32'h01F401F4);
    chk({decel2_time, speed_ref}, 32'h01F401F4);
    // boundaries then random values, readback and immediate effect at the ports
    for (i = 0; i < 20; i++) begin
      a = adr_tab[i % 5];
      e = (i < 5) ? 32'h0 : (i < 10) ? 32'hFFFF : $random(seed);
      wr(a, e);
      e = exp_of(a, e);
      rd(a);
      chk(v, e);
      if (a == MSPSEQ_RAMP_OFS) chk(ramp_time, e);
      if (a == MSPSEQ_DEC1_OFS) chk(decel1_time, e);
      if (a == MSPSEQ_DEC2_OFS) chk(decel2_time, e);
      if (a == MSPSEQ_SPEED_OFS) chk(speed_ref, e);
    end
    // every speed source code, plus an out-of-range code
    wr(MSPSEQ_SPEED_OFS, 32'h1234);
    for (i = 0; i < 6; i++) begin
      wr(MSPSEQ_SRC_OFS, i);
      e = exp_of(MSPSEQ_SRC_OFS, i);
      rd(MSPSEQ_SRC_OFS);
      chk(v, e);
      chk(speed_source, e[2:0]);
      chk(speed_ref, (e == 0) ? 16'h1234 : 16'h0000);
    end
    wr(MSPSEQ_SRC_OFS, 0);
    // unmapped place answers with an error and zero data
    rd(8'h2C);
    chk({r, v}, {2'b10, 32'h0});
    wr(8'h2C, 32'h5);
    chk(r, 2'b10);
    // start and stop by trigger edges
    wr(MSPSEQ_TRIG_OFS, 0);
    trg(1'b1);
    wait_issue(10);
    chk({ok, run_active}, 2'b11);
    trg(1'b0);
    repeat (3) @(posedge ref_clk);
    chk(run_active, 1'b0);
    wr(MSPSEQ_TRIG_OFS, 1);
    trg(1'b1);
    wait_issue(10);
    trg(1'b0);
    repeat (6) @(posedge ref_clk);
    chk({ok, run_active}, 2'b11);
    rd(MSPSEQ_STAT_OFS);
    chk(v[1:0], 2'b10);
    wr(MSPSEQ_TRIG_OFS, 0);
    trg(1'b1);
    trg(1'b0);
    repeat (3) @(posedge ref_clk);
    chk(run_active, 1'b0);
    // selection change from digital inputs retriggers only with bit one clear
    sel_from_di <= 1'b1;
    di_segment_sel <= 4'h5;
    wait_issue(10);
    chk({ok, cmd_segment}, {1'b1, 4'h5});
    trg(1'b1);
    trg(1'b0);
    wr(MSPSEQ_TRIG_OFS, 2);
    di_segment_sel <= 4'h9;
    wait_issue(12);
    chk({ok, run_active}, 2'b00);
    trg(1'b1);
    wait_issue(10);
    chk(ok, 1'b1);
    trg(1'b0);
    sel_from_di <= 1'b0;
    // send modes 0 and 1 with the ms unit, then mode 1 with the ten ms unit
    wr(MSPSEQ_IDLE_OFS, 2);
    for (i = 0; i < 3; i++) begin
      dly <= (i == 0) ? 8'h14 : 8'h3C;
      wr(MSPSEQ_SEND_OFS, (i == 0) ? 32'h0 : 32'h1);
      wr(MSPSEQ_UNIT_OFS, (i == 2) ? 32'h1 : 32'h0);
      rd(MSPSEQ_UNIT_OFS);
      chk(v, (i == 2) ? 32'h1 : 32'h0);
      wr(MSPSEQ_TRIG_OFS, 1);
      trg(1'b1);
      wait_issue(10);
      s0 = cmd_segment;
      wait_issue(100);
      if (i == 0) chk_rng(20 + MSD, 20 + 3 * MSD + 4);
      else if (i == 1) chk_rng(MSD, 3 * MSD + 4);
      else chk_rng(19 * MSD, 21 * MSD + 4);
      chk(cmd_segment, s0 + 4'h1);
      wr(MSPSEQ_TRIG_OFS, 0);
      trg(1'b0);
      repeat (3) @(posedge ref_clk);
    end
    results();
  end
endmodule
